/* tbd_decoder.v */
// Twelve-bit instruction decoder with skip, flush and direction latch logic.
// Operation
// - Accept 12-bit words: opcode plus operand fields.
// - Destination bit 0 selects accumulator, 1 file.
// - Bit field selects one of eight bits.
// - Literal is 8 bits; jump uses 9.
// - One cycle; two on skip or PC change.
// - Instruction cycle spans four oscillator periods.
// - Decode or/and/xor/add accumulator with file.
// - Decode subtract, store, zero file, zero accumulator.
// - Decode increment/decrement and their skip forms.
// - Decode rotates, invert, copy and nibble exchange.
// - Decode bit clear, set and two bit tests.
// - Decode load, or, and, xor literal forms.
// - Return with literal takes two cycles.
// - Call and nine-bit jump take two cycles.
// - Decode idle, prescale load, sleep, watchdog kick.
// - Direction load to 6 copies accumulator to latches.
// - PC writes except jump clear ninth bit.
// - Taken skip flushes fetched word as idle.
// - Port read-modify-write sources the pin values.
`timescale 1ns/10ps
`include "tbd_decoder_regs.vh"

module tbd_decoder (
    input wire clock,
    input wire sys_rst,
    input wire instr_valid,
    input wire [`TBD_WORD_W-1:0] instr_word,
    input wire [`TBD_DATA_W-1:0] file_latch_data,
    input wire [`TBD_DATA_W-1:0] port_pin_data,
    input wire [`TBD_DATA_W-1:0] acc_value,
    output reg cycle_en_q,
    output reg dec_valid_q,
    output reg [`TBD_OP_W-1:0] op_q,
    output reg [`TBD_FILE_W-1:0] file_addr_q,
    output reg dest_file_q,
    output reg [2:0] bit_sel_q,
    output reg [`TBD_DATA_W-1:0] bit_mask_q,
    output reg [`TBD_LIT_W-1:0] literal_q,
    output reg [`TBD_DATA_W-1:0] operand_q,
    output reg upd_z_q,
    output reg upd_c_q,
    output reg upd_half_carry_q,
    output reg upd_timeout_powerdown_q,
    output reg pc_write_q,
    output reg pc_bit8_clear_q,
    output reg two_cycle_q,
    output reg skip_taken_q,
    output reg flushed_q,
    output reg [`TBD_DATA_W-1:0] direction_load_q
);

    wire cyc_en;
    wire [`TBD_FILE_W-1:0] f_addr;
    wire d_sel;
    wire [2:0] b_sel;
    wire [`TBD_DATA_W-1:0] b_mask;
    wire [`TBD_LIT_W-1:0] lit8;
    wire [`TBD_LIT_W-1:0] lit9;

    reg [`TBD_OP_W-1:0] op_d;
    reg z_d;
    reg c_d;
    reg dc_d;
    reg tp_d;
    reg pc_wr_d;
    reg use_lit9_d;
    reg [`TBD_DATA_W-1:0] src_d;
    reg [`TBD_DATA_W-1:0] inc_d;
    reg [`TBD_DATA_W-1:0] dec_d;
    reg skip_d;
    reg flush_q;

    wire take;
    wire live;

    // Instruction-cycle enable derived from the oscillator clock.
    tbd_cycle_div u_div (
        .clock(clock),
        .sys_rst(sys_rst),
        .cyc_en_q(cyc_en)
    );

    // Field extraction of the incoming word.
    tbd_field_split u_split (
        .word(instr_word),
        .file_addr(f_addr),
        .dest_file(d_sel),
        .bit_sel(b_sel),
        .bit_mask(b_mask),
        .lit8(lit8),
        .lit9(lit9)
    );

    // A word is taken once per instruction cycle; in a flush slot it is dropped.
    assign take = cyc_en & instr_valid;
    assign live = take & ~flush_q;

    // Opcode classification; more specific patterns are listed first.
    always @* begin
        op_d = `TBD_OP_IDLE;
        z_d = 1'b0;
        c_d = 1'b0;
        dc_d = 1'b0;
        tp_d = 1'b0;
        pc_wr_d = 1'b0;
        use_lit9_d = 1'b0;
        casez (instr_word)
            12'h000: begin
                op_d = `TBD_OP_IDLE;
            end
            12'h002: begin
                op_d = `TBD_OP_PRESCALE_LOAD;
            end
            12'h003: begin
                op_d = `TBD_OP_SLEEP;
                tp_d = 1'b1;
            end
            12'h004: begin
                op_d = `TBD_OP_WATCHDOG_KICK;
                tp_d = 1'b1;
            end
            12'h006: begin
                op_d = `TBD_OP_DIRECTION_LOAD;
            end
            12'h040: begin
                op_d = `TBD_OP_ZERO_ACC;
                z_d = 1'b1;
            end
            12'b0000_001?_????: begin
                op_d = `TBD_OP_STORE_ACC;
            end
            12'b0000_011?_????: begin
                op_d = `TBD_OP_ZERO_FILE;
                z_d = 1'b1;
            end
            12'b0000_10??_????: begin
                op_d = `TBD_OP_SUB_ACC_FILE;
                z_d = 1'b1;
                c_d = 1'b1;
                dc_d = 1'b1;
            end
            12'b0000_11??_????: begin
                op_d = `TBD_OP_MINUS_ONE;
                z_d = 1'b1;
            end
            12'b0001_00??_????: begin
                op_d = `TBD_OP_OR_ACC_FILE;
                z_d = 1'b1;
            end
            12'b0001_01??_????: begin
                op_d = `TBD_OP_AND_ACC_FILE;
                z_d = 1'b1;
            end
            12'b0001_10??_????: begin
                op_d = `TBD_OP_XOR_ACC_FILE;
                z_d = 1'b1;
            end
            12'b0001_11??_????: begin
                op_d = `TBD_OP_ADD_ACC_FILE;
                z_d = 1'b1;
                c_d = 1'b1;
                dc_d = 1'b1;
            end
            12'b0010_00??_????: begin
                op_d = `TBD_OP_COPY_FILE;
                z_d = 1'b1;
            end
            12'b0010_01??_????: begin
                op_d = `TBD_OP_INVERT_FILE;
                z_d = 1'b1;
            end
            12'b0010_10??_????: begin
                op_d = `TBD_OP_PLUS_ONE;
                z_d = 1'b1;
            end
            12'b0010_11??_????: begin
                op_d = `TBD_OP_MINUS_ONE_SKIP;
            end
            12'b0011_00??_????: begin
                op_d = `TBD_OP_ROT_RIGHT;
                c_d = 1'b1;
            end
            12'b0011_01??_????: begin
                op_d = `TBD_OP_ROT_LEFT;
                c_d = 1'b1;
            end
            12'b0011_10??_????: begin
                op_d = `TBD_OP_NIBBLE_EXCH;
            end
            12'b0011_11??_????: begin
                op_d = `TBD_OP_PLUS_ONE_SKIP;
            end
            12'b0100_????_????: begin
                op_d = `TBD_OP_BIT_CLEAR;
            end
            12'b0101_????_????: begin
                op_d = `TBD_OP_BIT_SET;
            end
            12'b0110_????_????: begin
                op_d = `TBD_OP_TEST_SKIP_CLR;
            end
            12'b0111_????_????: begin
                op_d = `TBD_OP_TEST_SKIP_SET;
            end
            12'b1000_????_????: begin
                op_d = `TBD_OP_RETURN_LIT;
                pc_wr_d = 1'b1;
            end
            12'b1001_????_????: begin
                op_d = `TBD_OP_CALL;
                pc_wr_d = 1'b1;
            end
            12'b101?_????_????: begin
                op_d = `TBD_OP_JUMP_DIRECT;
                pc_wr_d = 1'b1;
                use_lit9_d = 1'b1;
            end
            12'b1100_????_????: begin
                op_d = `TBD_OP_LOAD_LITERAL;
            end
            12'b1101_????_????: begin
                op_d = `TBD_OP_OR_LITERAL;
                z_d = 1'b1;
            end
            12'b1110_????_????: begin
                op_d = `TBD_OP_AND_LITERAL;
                z_d = 1'b1;
            end
            12'b1111_????_????: begin
                op_d = `TBD_OP_XOR_LITERAL;
                z_d = 1'b1;
            end
            default: begin
                op_d = `TBD_OP_IDLE;
            end
        endcase
    end

    // Port reads take the pin levels so that inputs driven low externally
    // are not rewritten from a stale latch value.
    always @* begin
        if (f_addr == `TBD_PORT_ADDR) begin
            src_d = port_pin_data;
        end else begin
            src_d = file_latch_data;
        end
    end

    // Skip condition: zero result for the count forms, bit level for tests.
    always @* begin
        inc_d = src_d + `TBD_ONE8;
        dec_d = src_d - `TBD_ONE8;
        case (op_d)
            `TBD_OP_PLUS_ONE_SKIP: skip_d = (inc_d == `TBD_ZERO8);
            `TBD_OP_MINUS_ONE_SKIP: skip_d = (dec_d == `TBD_ZERO8);
            `TBD_OP_TEST_SKIP_CLR: skip_d = ~src_d[b_sel];
            `TBD_OP_TEST_SKIP_SET: skip_d = src_d[b_sel];
            default: skip_d = 1'b0;
        endcase
    end

    // Decoded outputs update once per instruction cycle. A flush slot
    // presents an idle operation with no flags, which is what makes the
    // preceding skip or branch cost its second cycle.
    always @(posedge clock) begin
        if (sys_rst) begin
            cycle_en_q <= 1'b0;
            dec_valid_q <= 1'b0;
            op_q <= `TBD_OP_IDLE;
            file_addr_q <= {`TBD_FILE_W{1'b0}};
            dest_file_q <= 1'b0;
            bit_sel_q <= 3'h0;
            bit_mask_q <= `TBD_ZERO8;
            literal_q <= {`TBD_LIT_W{1'b0}};
            operand_q <= `TBD_ZERO8;
            upd_z_q <= 1'b0;
            upd_c_q <= 1'b0;
            upd_half_carry_q <= 1'b0;
            upd_timeout_powerdown_q <= 1'b0;
            pc_write_q <= 1'b0;
            pc_bit8_clear_q <= 1'b0;
            two_cycle_q <= 1'b0;
            skip_taken_q <= 1'b0;
            flushed_q <= 1'b0;
            flush_q <= 1'b0;
        end else begin
            cycle_en_q <= cyc_en;
            dec_valid_q <= take;
            if (take) begin
                file_addr_q <= f_addr;
                dest_file_q <= d_sel;
                bit_sel_q <= b_sel;
                bit_mask_q <= b_mask;
                literal_q <= use_lit9_d ? lit9 : lit8;
                operand_q <= src_d;
                flushed_q <= flush_q;
                if (flush_q) begin
                    op_q <= `TBD_OP_IDLE;
                    upd_z_q <= 1'b0;
                    upd_c_q <= 1'b0;
                    upd_half_carry_q <= 1'b0;
                    upd_timeout_powerdown_q <= 1'b0;
                    pc_write_q <= 1'b0;
                    pc_bit8_clear_q <= 1'b0;
                    two_cycle_q <= 1'b0;
                    skip_taken_q <= 1'b0;
                    flush_q <= 1'b0;
                end else begin
                    op_q <= op_d;
                    upd_z_q <= z_d;
                    upd_c_q <= c_d;
                    upd_half_carry_q <= dc_d;
                    upd_timeout_powerdown_q <= tp_d;
                    pc_write_q <= pc_wr_d;
                    pc_bit8_clear_q <= pc_wr_d & ~use_lit9_d;
                    two_cycle_q <= pc_wr_d | skip_d;
                    skip_taken_q <= skip_d;
                    flush_q <= pc_wr_d | skip_d;
                end
            end
        end
    end

    // Direction latches: a one turns the pin driver off, so reset leaves
    // every pin floating until software chooses outputs.
    always @(posedge clock) begin
        if (sys_rst) begin
            direction_load_q <= `TBD_DIRECTION_LOAD_RST;
        end else if (live && op_d == `TBD_OP_DIRECTION_LOAD) begin
            direction_load_q <= acc_value;
        end
    end

endmodule

/* tbd_decoder_regs.vh */
// Constants shared by the twelve-bit instruction decoder files.
`ifndef TBD_DECODER_REGS_VH
`define TBD_DECODER_REGS_VH

// Word and field widths.
`define TBD_WORD_W 12
`define TBD_OP_W 6
`define TBD_FILE_W 5
`define TBD_DATA_W 8
`define TBD_LIT_W 9

// Field positions inside the instruction word.
`define TBD_F_LSB 0
`define TBD_F_MSB 4
`define TBD_D_POS 5
`define TBD_B_LSB 5
`define TBD_B_MSB 7
`define TBD_K8_MSB 7
`define TBD_K9_MSB 8

// Oscillator periods per instruction cycle.
`define TBD_OSC_PER_CYCLE 4
`define TBD_DIV_W 2
// Count at which the enable is raised; one early because the enable is registered.
`define TBD_EN_CNT 2'h2

// File address of the I/O port and the direction-load target.
`define TBD_PORT_ADDR 5'h06
`define TBD_DIR_TARGET 3'h6

// Reset values and byte constants.
`define TBD_DIRECTION_LOAD_RST 8'hFF
`define TBD_ZERO8 8'h00
`define TBD_ONE8 8'h01

// Operation codes presented on the decoded operation output.
`define TBD_OP_IDLE 6'h00
`define TBD_OP_ADD_ACC_FILE 6'h01
`define TBD_OP_AND_ACC_FILE 6'h02
`define TBD_OP_ZERO_FILE 6'h03
`define TBD_OP_ZERO_ACC 6'h04
`define TBD_OP_INVERT_FILE 6'h05
`define TBD_OP_MINUS_ONE 6'h06
`define TBD_OP_MINUS_ONE_SKIP 6'h07
`define TBD_OP_PLUS_ONE 6'h08
`define TBD_OP_PLUS_ONE_SKIP 6'h09
`define TBD_OP_OR_ACC_FILE 6'h0A
`define TBD_OP_COPY_FILE 6'h0B
`define TBD_OP_STORE_ACC 6'h0C
`define TBD_OP_ROT_LEFT 6'h0D
`define TBD_OP_ROT_RIGHT 6'h0E
`define TBD_OP_SUB_ACC_FILE 6'h0F
`define TBD_OP_NIBBLE_EXCH 6'h10
`define TBD_OP_XOR_ACC_FILE 6'h11
`define TBD_OP_BIT_CLEAR 6'h12
`define TBD_OP_BIT_SET 6'h13
`define TBD_OP_TEST_SKIP_CLR 6'h14
`define TBD_OP_TEST_SKIP_SET 6'h15
`define TBD_OP_AND_LITERAL 6'h16
`define TBD_OP_CALL 6'h17
`define TBD_OP_WATCHDOG_KICK 6'h18
`define TBD_OP_JUMP_DIRECT 6'h19
`define TBD_OP_OR_LITERAL 6'h1A
`define TBD_OP_LOAD_LITERAL 6'h1B
`define TBD_OP_PRESCALE_LOAD 6'h1C
`define TBD_OP_RETURN_LIT 6'h1D
`define TBD_OP_SLEEP 6'h1E
`define TBD_OP_DIRECTION_LOAD 6'h1F
`define TBD_OP_XOR_LITERAL 6'h20

`endif

/* tbd_cycle_div.v */
// Divider that turns the oscillator clock into instruction-cycle enables.
`timescale 1ns/10ps
`include "tbd_decoder_regs.vh"

module tbd_cycle_div (
    input wire clock,
    input wire sys_rst,
    output reg cyc_en_q
);

    reg [`TBD_DIV_W-1:0] cnt_q;

    // The enable fires on the last of each group of oscillator periods.
    always @(posedge clock) begin
        if (sys_rst) begin
            cnt_q <= {`TBD_DIV_W{1'b0}};
            cyc_en_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + {{(`TBD_DIV_W-1){1'b0}}, 1'b1};
            cyc_en_q <= (cnt_q == `TBD_EN_CNT);
        end
    end

endmodule

/* tbd_field_split.v */
// Operand field extraction for one instruction word.
`timescale 1ns/10ps
`include "tbd_decoder_regs.vh"

module tbd_field_split (
    input wire [`TBD_WORD_W-1:0] word,
    output wire [`TBD_FILE_W-1:0] file_addr,
    output wire dest_file,
    output wire [2:0] bit_sel,
    output wire [`TBD_DATA_W-1:0] bit_mask,
    output wire [`TBD_LIT_W-1:0] lit8,
    output wire [`TBD_LIT_W-1:0] lit9
);

    // Every field is cut out unconditionally; the decoder picks what it needs.
    assign file_addr = word[`TBD_F_MSB:`TBD_F_LSB];
    assign dest_file = word[`TBD_D_POS];
    assign bit_sel = word[`TBD_B_MSB:`TBD_B_LSB];
    assign bit_mask = `TBD_ONE8 << bit_sel;
    assign lit8 = {1'b0, word[`TBD_K8_MSB:0]};
    assign lit9 = word[`TBD_K9_MSB:0];

endmodule

/* tbd_prog_mem.sv */
// Behavioural program memory that feeds instruction words to the decoder.
`timescale 1ns/10ps
module tbd_prog_mem (
    input wire clock,
    input wire wr_en,
    input wire [6:0] wr_addr,
    input wire [11:0] wr_data,
    input wire rd_en,
    input wire [6:0] rd_addr,
    output wire [11:0] rd_data
);
    reg [11:0] mem [0:127];
    reg [11:0] last_q = 12'h000;
    // Writes load the program; the last word read is kept for the idle pattern.
    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            last_q <= rd_data;
        end
    end
    // A deselected memory does not hold its old word, so the inverse shows instead.
    assign rd_data = rd_en ? mem[rd_addr] : ~last_q;
endmodule

/* tbd_decoder_monitor.sv */
// Concurrent checks on the instruction decoder ports.
`timescale 1ns/10ps
`include "tbd_decoder_regs.vh"
module tbd_decoder_monitor (
    input wire clock,
    input wire sys_rst,
    input wire [7:0] port_pin_data,
    input wire cycle_en_q,
    input wire dec_valid_q,
    input wire [5:0] op_q,
    input wire [4:0] file_addr_q,
    input wire [2:0] bit_sel_q,
    input wire [7:0] bit_mask_q,
    input wire [8:0] literal_q,
    input wire [7:0] operand_q,
    input wire pc_write_q,
    input wire pc_bit8_clear_q,
    input wire two_cycle_q,
    input wire skip_taken_q,
    input wire flushed_q,
    input wire [7:0] direction_load_q
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // Decode results only appear together with an instruction-cycle enable.
    a_valid_on_enable: assert property (dec_valid_q |-> cycle_en_q)
        else $error("decode pulse outside an instruction cycle");
    a_cycle_four_clocks: assert property (cycle_en_q |=>
        !cycle_en_q [*3] ##1 cycle_en_q)
        else $error("instruction cycle is not four clocks");
    a_mask_from_bit: assert property (dec_valid_q |->
        bit_mask_q == (8'h01 << bit_sel_q))
        else $error("bit mask does not match bit number");
    a_two_cycle_cause: assert property (dec_valid_q |->
        two_cycle_q == (pc_write_q || skip_taken_q))
        else $error("two-cycle flag does not follow its causes");
    a_branch_two_cycle: assert property (dec_valid_q && (op_q == `TBD_OP_CALL ||
        op_q == `TBD_OP_RETURN_LIT || op_q == `TBD_OP_JUMP_DIRECT) |-> two_cycle_q && pc_write_q)
        else $error("branch not marked two cycles");
    a_jump_keeps_bit: assert property (dec_valid_q && pc_write_q |->
        pc_bit8_clear_q == (op_q != `TBD_OP_JUMP_DIRECT)) else $error("ninth bit clear wrong");
    a_short_literal: assert property (dec_valid_q && !flushed_q &&
        op_q != `TBD_OP_JUMP_DIRECT |-> literal_q[8] == 1'b0)
        else $error("literal wider than eight bits");
    a_flush_follows: assert property (dec_valid_q && two_cycle_q ##4 dec_valid_q |->
        flushed_q && op_q == `TBD_OP_IDLE && !two_cycle_q) else $error("slot after skip not flushed");
    a_direction_load_on_load: assert property ($changed(direction_load_q) |->
        dec_valid_q && op_q == `TBD_OP_DIRECTION_LOAD) else $error("direction latch moved");
    a_port_operand: assert property (dec_valid_q &&
        file_addr_q == `TBD_PORT_ADDR |-> operand_q == $past(port_pin_data))
        else $error("port operand not from pins");
    c_skip: cover property (dec_valid_q && skip_taken_q);
    c_flush: cover property (dec_valid_q && flushed_q);
    c_direction_load: cover property ($changed(direction_load_q));
endmodule

/* testbench.sv */
// Self-checking bench for the twelve-bit instruction decoder.
`timescale 1ns/10ps
`include "tbd_decoder_regs.vh"
module testbench;
    reg clock = 1'b0;
    reg sys_rst = 1'b1;
    reg instr_valid = 1'b0;
    reg wr_en = 1'b0;
    reg [6:0] wr_addr = 7'h00;
    reg [6:0] rd_addr = 7'h00;
    reg [11:0] wr_data = 12'h000;
    reg [7:0] file_latch_data = 8'h00;
    reg [7:0] port_pin_data = 8'h00;
    reg [7:0] acc_value = 8'h00;
    reg [7:0] direction_load_e = 8'hFF;
    reg flush_e = 1'b0;
    wire [11:0] instr_word;
    wire cycle_en_q, dec_valid_q, dest_file_q, upd_z_q, upd_c_q, upd_half_carry_q;
    wire upd_timeout_powerdown_q, pc_write_q, pc_bit8_clear_q, two_cycle_q, skip_taken_q, flushed_q;
    wire [5:0] op_q;
    wire [4:0] file_addr_q;
    wire [2:0] bit_sel_q;
    wire [7:0] bit_mask_q, operand_q, direction_load_q;
    wire [8:0] literal_q;
    wire [56:0] got;
    integer errors = 0;
    integer checks = 0;
    integer i;
    integer nd;
    logic [56:0] expq[$];
    logic [11:0] prog[$] = '{12'h000, 12'h002, 12'h003, 12'h004, 12'h006, 12'h040, 12'h001,
        12'h005, 12'h007, 12'h041, 12'h04F, 12'h1E1, 12'h141, 12'h101, 12'h1A6, 12'h0A1, 12'h021,
        12'h061, 12'h2A6, 12'h0E1, 12'h3C6, 12'h3C6, 12'h3E1, 12'h2E1, 12'h346, 12'h346,
        12'h306, 12'h266,
        12'h206, 12'h386, 12'h4E1, 12'h5A6, 12'h621, 12'h701, 12'h721, 12'h706, 12'h000, 12'hC5A,
        12'hD3C, 12'hEF0, 12'hF81, 12'h8A5, 12'h000, 12'h9FF, 12'h000, 12'hBFF, 12'h000, 12'hA12,
        12'h006, 12'h006};
    assign got = {op_q, upd_z_q, upd_c_q, upd_half_carry_q, upd_timeout_powerdown_q, pc_write_q,
        pc_bit8_clear_q, two_cycle_q, skip_taken_q, flushed_q, literal_q, operand_q, file_addr_q,
        dest_file_q, bit_sel_q, bit_mask_q, direction_load_q};
    tbd_prog_mem u_tbd_prog_mem (.clock(clock), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_en(instr_valid), .rd_addr(rd_addr), .rd_data(instr_word));
    tbd_decoder u_tbd_decoder (.clock, .sys_rst, .instr_valid, .instr_word, .file_latch_data,
        .port_pin_data, .acc_value, .cycle_en_q, .dec_valid_q, .op_q, .file_addr_q, .dest_file_q,
        .bit_sel_q, .bit_mask_q, .literal_q, .operand_q, .upd_z_q, .upd_c_q, .upd_half_carry_q,
        .upd_timeout_powerdown_q, .pc_write_q, .pc_bit8_clear_q, .two_cycle_q, .skip_taken_q,
        .flushed_q, .direction_load_q);
    // Free-running oscillator at 100 MHz.
    always #5 clock = ~clock;
    task automatic miss(input string m);
        begin
            errors++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask
    task automatic cmp(input [56:0] g, input [56:0] e);
        begin
            checks++;
            if (g !== e) begin
                errors++;
                $display("CHECK FAILED t=%0t decode got %h exp %h", $time, g, e);
            end
        end
    endtask
    task automatic final_report;
        begin
            $display("errors=%0d checks=%0d", errors, checks);
            if (errors == 0 && checks > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask
    // Notes the expected decode of one word; flush state and latches are tracked here.
    task automatic push(input [11:0] w);
        reg [5:0] o;
        reg [3:0] f;
        reg p;
        reg s;
        reg [7:0] v;
        begin
            v = (w[4:0] == `TBD_PORT_ADDR) ? port_pin_data : file_latch_data;
            f = 4'h0;
            o = `TBD_OP_IDLE;
            casez (w)
                12'h002: o = `TBD_OP_PRESCALE_LOAD;
                12'h003: {o, f} = {`TBD_OP_SLEEP, 4'h1};
                12'h004: {o, f} = {`TBD_OP_WATCHDOG_KICK, 4'h1};
                12'h006: o = `TBD_OP_DIRECTION_LOAD;
                12'h040: {o, f} = {`TBD_OP_ZERO_ACC, 4'h8};
                12'b0001_00??_????: {o, f} = {`TBD_OP_OR_ACC_FILE, 4'h8};
                12'b0001_01??_????: {o, f} = {`TBD_OP_AND_ACC_FILE, 4'h8};
                12'b0001_10??_????: {o, f} = {`TBD_OP_XOR_ACC_FILE, 4'h8};
                12'b0001_11??_????: {o, f} = {`TBD_OP_ADD_ACC_FILE, 4'hE};
                12'b0000_10??_????: {o, f} = {`TBD_OP_SUB_ACC_FILE, 4'hE};
                12'b0000_001?_????: o = `TBD_OP_STORE_ACC;
                12'b0000_011?_????: {o, f} = {`TBD_OP_ZERO_FILE, 4'h8};
                12'b0010_10??_????: {o, f} = {`TBD_OP_PLUS_ONE, 4'h8};
                12'b0000_11??_????: {o, f} = {`TBD_OP_MINUS_ONE, 4'h8};
                12'b0011_11??_????: o = `TBD_OP_PLUS_ONE_SKIP;
                12'b0010_11??_????: o = `TBD_OP_MINUS_ONE_SKIP;
                12'b0011_01??_????: {o, f} = {`TBD_OP_ROT_LEFT, 4'h4};
                12'b0011_00??_????: {o, f} = {`TBD_OP_ROT_RIGHT, 4'h4};
                12'b0010_01??_????: {o, f} = {`TBD_OP_INVERT_FILE, 4'h8};
                12'b0010_00??_????: {o, f} = {`TBD_OP_COPY_FILE, 4'h8};
                12'b0011_10??_????: o = `TBD_OP_NIBBLE_EXCH;
                12'b0100_????_????: o = `TBD_OP_BIT_CLEAR;
                12'b0101_????_????: o = `TBD_OP_BIT_SET;
                12'b0110_????_????: o = `TBD_OP_TEST_SKIP_CLR;
                12'b0111_????_????: o = `TBD_OP_TEST_SKIP_SET;
                12'b1100_????_????: o = `TBD_OP_LOAD_LITERAL;
                12'b1101_????_????: {o, f} = {`TBD_OP_OR_LITERAL, 4'h8};
                12'b1110_????_????: {o, f} = {`TBD_OP_AND_LITERAL, 4'h8};
                12'b1111_????_????: {o, f} = {`TBD_OP_XOR_LITERAL, 4'h8};
                12'b1000_????_????: o = `TBD_OP_RETURN_LIT;
                12'b1001_????_????: o = `TBD_OP_CALL;
                12'b101?_????_????: o = `TBD_OP_JUMP_DIRECT;
                default: o = `TBD_OP_IDLE;
            endcase
            p = (o == `TBD_OP_RETURN_LIT) || (o == `TBD_OP_CALL) || (o == `TBD_OP_JUMP_DIRECT);
            s = (o == `TBD_OP_PLUS_ONE_SKIP && v == 8'hFF) || (o == `TBD_OP_MINUS_ONE_SKIP
                && v == 8'h01) || (o == `TBD_OP_TEST_SKIP_CLR && !v[w[7:5]])
                || (o == `TBD_OP_TEST_SKIP_SET && v[w[7:5]]);
            if (flush_e) {o, f, p, s} = 12'h000;
            if (!flush_e && o == `TBD_OP_DIRECTION_LOAD) direction_load_e = acc_value;
            expq.push_back({o, f, p, p && o != `TBD_OP_JUMP_DIRECT, p || s, s, flush_e,
                (w[11:9] == 3'b101) ? w[8:0] : {1'b0, w[7:0]}, v, w[4:0], w[5], w[7:5],
                8'h01 << w[7:5], direction_load_e});
            flush_e = !flush_e && (p || s);
        end
    endtask
    // Returns at the falling edge after the next cycle enable; a missing enable ends the run.
    task automatic wait_take;
        integer n;
        begin
            for (n = 0; n < 8; n++) begin
                @(negedge clock);
                if (cycle_en_q === 1'b1) return;
            end
            miss("no instruction cycle enable");
            final_report();
        end
    endtask
    // Each decode pulse consumes the oldest note; a pulse with no note is a fault itself.
    always @(negedge clock) begin
        if (dec_valid_q === 1'b1) begin
            if (expq.size() == 0) miss("unexpected decode pulse");
            else cmp(got, expq.pop_front());
        end
    end
    // Reset, load the program, then feed one word per cycle with one idle slot in every seven words.
    initial begin
        void'($urandom(73));
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
        nd = prog.size();
        repeat (60) prog.push_back(12'($urandom));
        for (i = 0; i < prog.size(); i++) begin
            @(negedge clock);
            wr_en = 1'b1;
            wr_addr = 7'(i);
            wr_data = prog[i];
        end
        @(negedge clock);
        wr_en = 1'b0;
        for (i = 0; i < prog.size(); i++) begin
            if (i % 7 == 4) begin
                instr_valid = 1'b0;
                wait_take();
            end
            instr_valid = 1'b1;
            rd_addr = 7'(i);
            file_latch_data = (i < nd) ? 8'h01 : 8'($urandom);
            port_pin_data = (i < nd) ? 8'hFF : 8'($urandom);
            acc_value = 8'($urandom);
            push(prog[i]);
            wait_take();
        end
        instr_valid = 1'b0;
        repeat (8) @(negedge clock);
        if (expq.size() != 0) miss("decode pulses missing");
        final_report();
    end
endmodule
bind tbd_decoder tbd_decoder_monitor u_tbd_decoder_monitor (.clock, .sys_rst, .port_pin_data,
    .cycle_en_q, .dec_valid_q, .op_q, .file_addr_q, .bit_sel_q, .bit_mask_q, .literal_q,
    .operand_q, .pc_write_q, .pc_bit8_clear_q, .two_cycle_q, .skip_taken_q, .flushed_q, .direction_load_q);
